// ==== logic/flash_clk_div.sv ====
// flash timing clock enable: optional divide by eight, then ratio plus one
// assumes all inputs come from flops on mclk_i
`timescale 1ns/1ps
module flash_clk_div
(
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       en_i,
   input  wire logic       prescale_i,
   input  wire logic [5:0] ratio_i,
   output logic            tick_o
);
   logic [2:0] pre_reg;
   logic [5:0] div_reg;
   logic       pre_tick;

   // divider input is bus clock or bus clock over eight
   assign pre_tick = !prescale_i || (pre_reg == 3'(flash_sec_pkg::PRESCALE_DIV - 1));

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         pre_reg <= 3'h0;
      else if (!en_i || !prescale_i)
         pre_reg <= 3'h0;
      else
         pre_reg <= pre_reg + 3'h1;
   end

   // one tick per ratio plus one divider inputs; each tick is one flash period
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         div_reg <= 6'h00;
         tick_o  <= 1'b0;
      end
      else if (!en_i)
      begin
         div_reg <= 6'h00;
         tick_o  <= 1'b0;
      end
      else if (pre_tick && div_reg == ratio_i)
      begin
         div_reg <= 6'h00;
         tick_o  <= 1'b1;
      end
      else
      begin
         div_reg <= pre_tick ? div_reg + 6'h01 : div_reg;
         tick_o  <= 1'b0;
      end
   end

   prescale_gap_a : assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (tick_o && en_i && prescale_i && $stable(prescale_i)) |=> !tick_o [*7])
      else $error("prescaled flash tick came too early");
   unit_ratio_a : assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (tick_o && en_i && !prescale_i && ratio_i == 6'h00) |=> tick_o)
      else $error("ratio zero did not tick every cycle");
endmodule

// ==== logic/flash_key_check.sv ====
// backdoor key comparator: eight ordered, non-adjacent byte writes
// assumes wr_i is already qualified by source and key mode
`timescale 1ns/1ps
module flash_key_check
(
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        clear_i,
   input  wire logic        wr_i,
   input  wire logic [2:0]  idx_i,
   input  wire logic [7:0]  data_i,
   input  wire logic [63:0] key_i,
   output logic             match_o
);
   logic [3:0] cnt_reg;
   logic       bad_reg;
   logic       last_wr_reg;
   logic       good;

   // in order, matching, and never on the cycle right after the previous write
   assign good = (4'(idx_i) == cnt_reg) && !last_wr_reg &&
                 (data_i == key_i[8*idx_i +: 8]);

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         cnt_reg     <= 4'h0;
         bad_reg     <= 1'b0;
         last_wr_reg <= 1'b0;
      end
      else if (clear_i)
      begin
         cnt_reg     <= 4'h0;
         bad_reg     <= 1'b0;
         last_wr_reg <= 1'b0;
      end
      else
      begin
         last_wr_reg <= wr_i;
         if (wr_i)
         begin
            cnt_reg <= (cnt_reg == 4'(flash_sec_pkg::KEY_LEN)) ? cnt_reg : cnt_reg + 4'h1;
            bad_reg <= bad_reg || !good;
         end
      end
   end

   assign match_o = (cnt_reg == 4'(flash_sec_pkg::KEY_LEN)) && !bad_reg;

   adjacent_bad_a : assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      (wr_i && !clear_i) ##1 (wr_i && !clear_i) |=> !match_o)
      else $error("adjacent key writes were accepted");
endmodule

// ==== logic/flash_sec_pkg.sv ====
// constants shared by the flash security gate and its helpers
// assumes 16-bit cpu addresses and byte-wide memory data
package flash_sec_pkg;
   // apb register byte offsets
   localparam logic [11:0] OFF_RATIO   = 12'h000;
   localparam logic [11:0] OFF_CONFIG  = 12'h004;
   localparam logic [11:0] OFF_OPTION  = 12'h008;
   localparam logic [11:0] OFF_PROTECT = 12'h00C;
   localparam logic [11:0] OFF_STATUS  = 12'h010;
   // flash_clock_ratio fields
   localparam int RATIO_LOADED_BIT = 7;
   localparam int PRESCALE_BIT     = 6;
   localparam int RATIO_MSB        = 5;
   localparam logic [7:0] RATIO_RESET = 8'h00;
   // option_working_reg fields and protection_working_reg reset value
   localparam int BACKDOOR_BIT = 7;
   localparam int SEC_HI_BIT   = 1;
   localparam int SEC_LO_BIT   = 0;
   localparam logic [1:0] SEC_UNSECURED = 2'h2;
   localparam logic [7:0] OPTION_RESET  = 8'hFF;
   localparam logic [7:0] PROTECT_RESET = 8'hFF;
   // flash_config_reg and status fields
   localparam int KEY_MODE_BIT   = 0;
   localparam int ST_SECURED_BIT = 0;
   localparam int ST_LOADED_BIT  = 1;
   localparam int ST_MATCH_BIT   = 2;
   localparam int ST_DEBUG_BIT   = 3;
   // memory map
   localparam logic [15:0] RAM_LO   = 16'h0080;
   localparam logic [15:0] RAM_HI   = 16'h027F;
   localparam logic [15:0] FLASH_LO = 16'hE000;
   localparam logic [15:0] FLASH_HI = 16'hFFFF;
   localparam logic [15:0] KEY_BASE = 16'hFFB0;
   localparam int          KEY_LEN  = 8;
   // clock divider
   localparam int PRESCALE_DIV = 8;

   function automatic logic is_secure_addr(input logic [15:0] addr);
      return ((addr >= RAM_LO) && (addr <= RAM_HI)) ||
             ((addr >= FLASH_LO) && (addr <= FLASH_HI));
   endfunction

   function automatic logic is_key_addr(input logic [15:0] addr);
      return (addr >= KEY_BASE) && (addr < (KEY_BASE + 16'(KEY_LEN)));
   endfunction

   function automatic logic sec_engaged(input logic [1:0] bits);
      return bits != SEC_UNSECURED;
   endfunction
endpackage

// ==== logic/flash_security.sv ====
// flash and ram security gate, backdoor key unlock and flash clock divider
// assumes an apb master for registers and a byte memory bus whose array read is
// combinational on mem_addr_i; pdebug_i marks background debug apb transfers
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module flash_security
(
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   input  wire logic        pdebug_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [7:0]  option_nv_i,
   input  wire logic [7:0]  protect_nv_i,
   input  wire logic [63:0] key_nv_i,
   input  wire logic        blank_pass_i,
   input  wire logic        mem_req_i,
   input  wire logic        mem_we_i,
   input  wire logic [15:0] mem_addr_i,
   input  wire logic [7:0]  mem_wdata_i,
   input  wire logic        mem_src_secure_i,
   input  wire logic        mem_src_debug_i,
   input  wire logic [7:0]  mem_rdata_i,
   output logic             mem_req_o,
   output logic             mem_we_o,
   output logic      [15:0] mem_addr_o,
   output logic      [7:0]  mem_wdata_o,
   output logic      [7:0]  mem_rdata_o,
   input  wire logic        dbg_enable_req_i,
   output logic             dbg_enable_o,
   output logic             secured_o,
   output logic             pe_enable_o,
   output logic      [7:0]  protect_o,
   output logic             flash_tick_o
);
   logic       load_done_reg;
   logic [7:0] option_working_reg;
   logic [7:0] protection_working_reg;
   logic [6:0] ratio_reg;
   logic       ratio_loaded_reg;
   logic       key_mode_reg;
   logic       pready_reg;
   logic       secured;
   logic       backdoor_en;
   logic       blocked;
   logic       key_hit;
   logic       key_wr;
   logic       key_match;
   logic       key_clear;
   logic       unlock_key;
   logic       apb_access;
   logic       wr_fire;
   logic       wr_ratio;
   logic       wr_config;
   logic       wr_protect;
   logic       mapped;
   logic [7:0] rd_byte;
   logic [7:0] status_byte;
   logic [7:0] config_byte;

   // security decode, re-evaluated on every access
   assign secured     = flash_sec_pkg::sec_engaged(
                           option_working_reg[flash_sec_pkg::SEC_HI_BIT:
                                              flash_sec_pkg::SEC_LO_BIT]);
   assign backdoor_en = option_working_reg[flash_sec_pkg::BACKDOOR_BIT];
   // one gate term drives both the read path and the write strobe
   assign blocked     = secured && flash_sec_pkg::is_secure_addr(mem_addr_i) &&
                        (mem_src_debug_i || !mem_src_secure_i);
   assign key_hit     = key_mode_reg && flash_sec_pkg::is_key_addr(mem_addr_i);
   assign key_wr      = mem_req_i && mem_we_i && key_hit && backdoor_en &&
                        mem_src_secure_i && !mem_src_debug_i;

   // apb decode; one wait state so every answer comes from a flop
   assign apb_access = psel_i && penable_i;
   assign wr_fire    = apb_access && pready_reg && pwrite_i && pstrb_i[0];
   assign wr_ratio   = wr_fire && (paddr_i == flash_sec_pkg::OFF_RATIO);
   assign wr_config  = wr_fire && (paddr_i == flash_sec_pkg::OFF_CONFIG);
   assign wr_protect = wr_fire && (paddr_i == flash_sec_pkg::OFF_PROTECT);
   assign mapped     = (paddr_i == flash_sec_pkg::OFF_RATIO) ||
                       (paddr_i == flash_sec_pkg::OFF_CONFIG) ||
                       (paddr_i == flash_sec_pkg::OFF_OPTION) ||
                       (paddr_i == flash_sec_pkg::OFF_PROTECT) ||
                       (paddr_i == flash_sec_pkg::OFF_STATUS);

   // key unlock happens on the write that clears key access mode
   assign key_clear  = wr_config && !key_mode_reg && pwdata_i[flash_sec_pkg::KEY_MODE_BIT];
   assign unlock_key = wr_config && key_mode_reg && !pwdata_i[flash_sec_pkg::KEY_MODE_BIT] &&
                       key_match && backdoor_en;

   // bytes built by field position so the bit map lives in the package only
   always_comb
   begin
      status_byte = 8'h00;
      config_byte = 8'h00;
      status_byte[flash_sec_pkg::ST_SECURED_BIT] = secured;
      status_byte[flash_sec_pkg::ST_LOADED_BIT]  = load_done_reg;
      status_byte[flash_sec_pkg::ST_MATCH_BIT]   = key_match;
      status_byte[flash_sec_pkg::ST_DEBUG_BIT]   = dbg_enable_o;
      config_byte[flash_sec_pkg::KEY_MODE_BIT]   = key_mode_reg;
   end

   always_comb
   begin
      rd_byte = 8'h00;
      case (paddr_i)
         flash_sec_pkg::OFF_RATIO:   rd_byte = {ratio_loaded_reg, ratio_reg};
         flash_sec_pkg::OFF_CONFIG:  rd_byte = config_byte;
         flash_sec_pkg::OFF_OPTION:  rd_byte = option_working_reg;
         flash_sec_pkg::OFF_PROTECT: rd_byte = protection_working_reg;
         flash_sec_pkg::OFF_STATUS:  rd_byte = status_byte;
         default:                    rd_byte = 8'h00;
      endcase
   end

   // nonvolatile copy happens on the first edge after reset release, since an
   // asynchronous reset may only load constants
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         load_done_reg <= 1'b0;
      else
         load_done_reg <= 1'b1;
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         option_working_reg <= flash_sec_pkg::OPTION_RESET;
      else if (!load_done_reg)
         option_working_reg <= option_nv_i;
      else if (blank_pass_i || unlock_key)
         option_working_reg[flash_sec_pkg::SEC_HI_BIT:flash_sec_pkg::SEC_LO_BIT]
            <= flash_sec_pkg::SEC_UNSECURED;
   end

   // runaway application code cannot alter block protection
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         protection_working_reg <= flash_sec_pkg::PROTECT_RESET;
      else if (!load_done_reg)
         protection_working_reg <= protect_nv_i;
      else if (wr_protect && pdebug_i)
         protection_working_reg <= pwdata_i[7:0];
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         ratio_reg        <= flash_sec_pkg::RATIO_RESET[6:0];
         ratio_loaded_reg <= flash_sec_pkg::RATIO_RESET[flash_sec_pkg::RATIO_LOADED_BIT];
      end
      else if (wr_ratio && !ratio_loaded_reg)
      begin
         ratio_reg        <= pwdata_i[6:0];
         ratio_loaded_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         key_mode_reg <= 1'b0;
      else if (wr_config)
         key_mode_reg <= pwdata_i[flash_sec_pkg::KEY_MODE_BIT];
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         pready_reg <= 1'b0;
         prdata_o   <= 32'h0000_0000;
         pslverr_o  <= 1'b0;
      end
      else
      begin
         pready_reg <= apb_access && !pready_reg;
         if (apb_access && !pready_reg)
         begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            pslverr_o <= !mapped;
         end
         else
         begin
            pslverr_o <= 1'b0;
         end
      end
   end

   assign pready_o = pready_reg;

   // memory path, gated and registered toward the array
   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         mem_req_o   <= 1'b0;
         mem_we_o    <= 1'b0;
         mem_addr_o  <= 16'h0000;
         mem_wdata_o <= 8'h00;
         mem_rdata_o <= 8'h00;
      end
      else
      begin
         mem_req_o   <= mem_req_i && !blocked && !(mem_we_i && key_hit);
         mem_we_o    <= mem_req_i && mem_we_i && !blocked && !key_hit;
         mem_addr_o  <= mem_addr_i;
         mem_wdata_o <= mem_wdata_i;
         mem_rdata_o <= (mem_req_i && !mem_we_i && !blocked) ? mem_rdata_i : 8'h00;
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         dbg_enable_o <= 1'b0;
         secured_o    <= 1'b1;
         protect_o    <= flash_sec_pkg::PROTECT_RESET;
      end
      else
      begin
         dbg_enable_o <= dbg_enable_req_i && !secured;
         secured_o    <= secured;
         protect_o    <= protection_working_reg;
      end
   end

   // erase and program stay off until the ratio has been written
   assign pe_enable_o = ratio_loaded_reg;

   flash_key_check u_key
   (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .clear_i   (key_clear),
      .wr_i      (key_wr),
      .idx_i     (mem_addr_i[2:0]),
      .data_i    (mem_wdata_i),
      .key_i     (key_nv_i),
      .match_o   (key_match)
   );

   flash_clk_div u_div
   (
      .mclk_i     (mclk_i),
      .sys_rst_i  (sys_rst_i),
      .en_i       (ratio_loaded_reg),
      .prescale_i (ratio_reg[flash_sec_pkg::PRESCALE_BIT]),
      .ratio_i    (ratio_reg[flash_sec_pkg::RATIO_MSB:0]),
      .tick_o     (flash_tick_o)
   );

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   sequence blocked_read_s;
      mem_req_i && !mem_we_i && blocked;
   endsequence
   sequence secure_write_s;
      mem_req_i && mem_we_i && mem_src_secure_i && !mem_src_debug_i && !key_hit;
   endsequence

   blocked_read_a : assert property (blocked_read_s |=> mem_rdata_o == 8'h00)
      else $error("blocked read returned data");
   blocked_write_a : assert property ((mem_req_i && blocked) |=> !mem_we_o && !mem_req_o)
      else $error("blocked access reached the array");
   secure_code_a : assert property (secure_write_s |=> mem_we_o)
      else $error("secure code write was dropped");
   option_load_a : assert property (!load_done_reg |=>
      option_working_reg == $past(option_nv_i))
      else $error("option byte not copied after reset");
   sec_decode_a : assert property (load_done_reg |=>
      secured_o == ($past(option_working_reg[1:0]) != 2'h2))
      else $error("security decode wrong");
   dbg_refuse_a : assert property (secured |=> !dbg_enable_o)
      else $error("debug module enabled while secured");
   key_disabled_a : assert property (!backdoor_en |-> !unlock_key && !key_wr)
      else $error("key path active without backdoor enable");
   key_not_cmd_a : assert property ((mem_req_i && mem_we_i && key_hit) |=> !mem_we_o)
      else $error("key write passed to the array");
   unlock_stays_a : assert property (unlock_key |=> !secured [*8])
      else $error("key unlock did not hold");
   debug_key_a : assert property (mem_src_debug_i |-> !key_wr)
      else $error("debug source entered a key byte");
   prot_app_a : assert property ((wr_protect && !pdebug_i && load_done_reg) |=>
      $stable(protection_working_reg))
      else $error("application write changed protection");
   blank_unlock_a : assert property ((blank_pass_i && load_done_reg) |=> !secured ##1 !secured_o)
      else $error("blank check did not unsecure");
   ratio_once_a : assert property ((wr_ratio && ratio_loaded_reg) |=> $stable(ratio_reg))
      else $error("second ratio write took effect");
   loaded_flag_a : assert property (wr_ratio |=> ratio_loaded_reg && pe_enable_o)
      else $error("loaded flag not set by ratio write");
   no_tick_a : assert property (!ratio_loaded_reg |=> !flash_tick_o)
      else $error("flash tick before ratio loaded");
   apb_answer_a : assert property ((apb_access && !pready_reg) |=>
      pready_o && (pslverr_o == !$past(mapped)))
      else $error("apb answer missing or wrong");
   option_ro_a : assert property ((load_done_reg && !blank_pass_i && !unlock_key) |=>
      $stable(option_working_reg))
      else $error("option register changed without cause");
   open_read_a : assert property ((mem_req_i && !mem_we_i && !blocked) |=>
      mem_rdata_o == $past(mem_rdata_i))
      else $error("open read lost its data");
   loaded_stays_a : assert property (ratio_loaded_reg |=> ratio_loaded_reg)
      else $error("loaded flag fell before reset");
   dbg_allow_a : assert property ((dbg_enable_req_i && !secured) |=> dbg_enable_o)
      else $error("debug module refused while unsecured");

   // unlock takes two steps: option bits first, the registered output one edge later
   sequence key_close_s;
      wr_config && key_mode_reg && !pwdata_i[flash_sec_pkg::KEY_MODE_BIT] &&
      key_match && backdoor_en;
   endsequence
   sequence unsecured_s;
      !secured ##1 !secured_o;
   endsequence

   key_unlock_a : assert property (key_close_s |=> unsecured_s)
      else $error("matching key did not unsecure");
endmodule

// ==== testbench/flash_security_and_clock_divider_bench.sv ====
// self-checking bench for the flash security gate and clock divider
// assumes one 100 mhz clock; apb and memory bus tasks play cpu and debug masters
`timescale 1ns/1ps
module flash_security_and_clock_divider_bench;
   localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
   logic        mclk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, pdebug_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic [3:0]  pstrb_i = 4'hF;
   logic        pready_o, pslverr_o, err;
   logic [7:0]  option_nv_i = 8'hFF;
   logic        blank_pass_i = 1'b0, dbg_enable_req_i = 1'b1;
   logic        mem_req_i = 1'b0, mem_we_i = 1'b0, mem_src_secure_i = 1'b0;
   logic        mem_src_debug_i = 1'b0;
   logic [15:0] mem_addr_i = 16'h0, mem_addr_o;
   logic [7:0]  mem_wdata_i = 8'h0, mem_rdata_i, mem_wdata_o, mem_rdata_o, protect_o;
   logic        mem_req_o, mem_we_o, dbg_enable_o, secured_o, pe_enable_o, flash_tick_o;
   int          fail_count = 0;
   int          n_checks = 0;
   int          p;

   always #5 mclk_i = ~mclk_i;

   flash_security i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .pdebug_i(pdebug_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .option_nv_i(option_nv_i), .protect_nv_i(8'hF8),
      .key_nv_i(KEY), .blank_pass_i(blank_pass_i), .mem_req_i(mem_req_i),
      .mem_we_i(mem_we_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
      .mem_src_secure_i(mem_src_secure_i), .mem_src_debug_i(mem_src_debug_i),
      .mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_o(mem_rdata_o),
      .dbg_enable_req_i(dbg_enable_req_i), .dbg_enable_o(dbg_enable_o),
      .secured_o(secured_o), .pe_enable_o(pe_enable_o), .protect_o(protect_o),
      .flash_tick_o(flash_tick_o));

   mem_array_model i_mem (.clk_i(mclk_i), .we_i(mem_we_o), .addr_i(mem_addr_o),
      .wdata_i(mem_wdata_o), .raddr_i(mem_addr_i), .rdata_o(mem_rdata_i));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // request held until the edge that samples pready high; only the watchdog ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      input logic dbg);
      @(posedge mclk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pdebug_i} <= {2'b10, w, a, 24'h0, d, dbg};
      @(posedge mclk_i);
      penable_i <= 1'b1;
      do
         @(posedge mclk_i);
      while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
      // outputs copied from a written register settle one edge after the write
      repeat (2) @(negedge mclk_i);
   endtask

   // one-cycle request; outputs looked at in the cycle after
   task automatic mem_op(input logic we, input logic [15:0] a, input logic [7:0] d,
                         input logic sec, input logic dbg);
      @(posedge mclk_i);
      {mem_req_i, mem_we_i, mem_addr_i, mem_wdata_i, mem_src_secure_i, mem_src_debug_i}
         <= {1'b1, we, a, d, sec, dbg};
      @(posedge mclk_i);
      mem_req_i <= 1'b0;
      @(negedge mclk_i);
   endtask

   task automatic do_reset(input logic [7:0] opt);
      @(posedge mclk_i);
      sys_rst_i <= 1'b1;
      option_nv_i <= opt;
      repeat (10) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask

   // each key byte call leaves an idle cycle before the next, never adjacent
   task automatic key_entry(input logic dbg);
      apb(1'b1, flash_sec_pkg::OFF_CONFIG, 8'h01, 1'b0);
      for (int n = 0; n < 8; n++)
      begin
         mem_op(1'b1, flash_sec_pkg::KEY_BASE + 16'(n), KEY[8*n +: 8], !dbg, dbg);
         chk("key write strobe", {31'h0, mem_we_o}, 32'h0);
      end
      apb(1'b1, flash_sec_pkg::OFF_CONFIG, 8'h00, 1'b0);
      repeat (2) @(negedge mclk_i);
   endtask

   task automatic tick_period();
      int c;
      c = 0;
      while (flash_tick_o !== 1'b1 && c < 1000)
      begin
         @(negedge mclk_i);
         c++;
      end
      p = 0;
      do
      begin
         @(negedge mclk_i);
         p++;
      end
      while (flash_tick_o !== 1'b1 && p < 1000);
   endtask

   initial
   begin
      for (int s = 0; s < 4; s++)
      begin
         do_reset({6'h3F, 2'(s)});
         chk("secured", {31'h0, secured_o}, {31'h0, 2'(s) != 2'b10});
      end
      $display("security decode test done");
      do_reset(8'hFF);
      apb(1'b0, flash_sec_pkg::OFF_OPTION, 8'h00, 1'b0);
      chk("option", rd, 32'hFF);
      mem_op(1'b0, 16'h0100, 8'h00, 1'b0, 1'b0);
      chk("blocked read", {23'h0, mem_req_o, mem_rdata_o}, 32'h0);
      mem_op(1'b1, 16'hE010, 8'h77, 1'b0, 1'b1);
      chk("blocked write", {31'h0, mem_we_o}, 32'h0);
      mem_op(1'b0, 16'h0100, 8'h00, 1'b1, 1'b0);
      chk("secure read", {24'h0, mem_rdata_o}, 32'h5A);
      mem_op(1'b1, 16'h0200, 8'hC3, 1'b1, 1'b0);
      chk("secure write", {7'h0, mem_we_o, mem_addr_o, mem_wdata_o}, 32'h0102_00C3);
      mem_op(1'b0, 16'h0200, 8'h00, 1'b1, 1'b0);
      chk("secure readback", {24'h0, mem_rdata_o}, 32'hC3);
      mem_op(1'b0, 16'h0010, 8'h00, 1'b0, 1'b1);
      chk("debug page read", {24'h0, mem_rdata_o}, 32'h4A);
      chk("debug module", {31'h0, dbg_enable_o}, 32'h0);
      $display("gate test done");
      chk("protect load", {24'h0, protect_o}, 32'hF8);
      apb(1'b1, flash_sec_pkg::OFF_PROTECT, 8'h3C, 1'b0);
      chk("protect app write", {24'h0, protect_o}, 32'hF8);
      apb(1'b1, flash_sec_pkg::OFF_PROTECT, 8'h3C, 1'b1);
      chk("protect debug write", {24'h0, protect_o}, 32'h3C);
      apb(1'b0, 12'h020, 8'h00, 1'b0);
      chk("unmapped", {31'h0, err}, 32'h1);
      $display("register test done");
      apb(1'b0, flash_sec_pkg::OFF_RATIO, 8'h00, 1'b0);
      chk("ratio reset", rd, 32'h00);
      chk("pe before", {31'h0, pe_enable_o}, 32'h0);
      apb(1'b1, flash_sec_pkg::OFF_RATIO, 8'h03, 1'b0);
      apb(1'b1, flash_sec_pkg::OFF_RATIO, 8'h45, 1'b0);
      apb(1'b0, flash_sec_pkg::OFF_RATIO, 8'h00, 1'b0);
      chk("ratio once", rd, 32'h83);
      chk("pe after", {31'h0, pe_enable_o}, 32'h1);
      tick_period();
      chk("tick period", 32'(p), 32'h4);
      $display("divider test done");
      key_entry(1'b1);
      chk("debug key", {31'h0, secured_o}, 32'h1);
      key_entry(1'b0);
      chk("key unlock", {31'h0, secured_o}, 32'h0);
      apb(1'b0, flash_sec_pkg::OFF_OPTION, 8'h00, 1'b0);
      chk("option unlocked", rd, 32'hFE);
      mem_op(1'b0, 16'h0100, 8'h00, 1'b0, 1'b0);
      chk("open read", {24'h0, mem_rdata_o}, 32'h5A);
      chk("debug module on", {31'h0, dbg_enable_o}, 32'h1);
      apb(1'b0, flash_sec_pkg::OFF_STATUS, 8'h00, 1'b0);
      chk("status unlocked", rd, 32'h0E);
      $display("key test done");
      do_reset(8'h7F);
      // bus over eight over sixty-four lands inside the flash clock window
      apb(1'b1, flash_sec_pkg::OFF_RATIO, 8'h7F, 1'b0);
      tick_period();
      chk("prescaled period", 32'(p), 32'h200);
      key_entry(1'b0);
      chk("backdoor off", {31'h0, secured_o}, 32'h1);
      @(posedge mclk_i);
      blank_pass_i <= 1'b1;
      @(posedge mclk_i);
      blank_pass_i <= 1'b0;
      repeat (3) @(negedge mclk_i);
      chk("blank unlock", {31'h0, secured_o}, 32'h0);
      $display("erase path test done");
      complete_run();
   end

   // whole run is under two thousand cycles
   initial
   begin
      #500000;
      fail_count++;
      complete_run();
   end
endmodule

// ==== testbench/mem_array_model.sv ====
// byte memory array standing behind the gate's memory bus
// assumes reads are combinational on the raw request address
`timescale 1ns/1ps
module mem_array_model
(
   input  wire logic        clk_i,
   input  wire logic        we_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   input  wire logic [15:0] raddr_i,
   output logic      [7:0]  rdata_o
);
   logic [7:0] mem [0:65535];

   // unwritten bytes hold the low address byte xor 5A, zero only where that byte is 5A, so a blocked read is told apart
   initial
   begin
      for (int a = 0; a < 65536; a++)
         mem[a] = 8'(a) ^ 8'h5A;
   end

   always @(posedge clk_i)
      if (we_i)
         mem[addr_i] <= wdata_i;

   assign rdata_o = mem[raddr_i];
endmodule
